// [rtl/tcio_channel.sv]
/*
 * one timer channel: apb registers, clock select, counter clear, compare
 * and capture on two general registers with their pins.
 * assumes apb master on core_clk; pins arrive asynchronously from outside
 * (sync_clear_in from other channels is same-clock logic and is not synchronised).
 */
`timescale 1ns/1ps
module tcio_channel #(
    parameter int CHANNEL = 0,
    parameter int CNT_W = 16
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic standby,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clock_in_a,
    input wire logic ext_clock_in_b,
    input wire logic ext_clock_in_c,
    input wire logic ext_clock_in_d,
    input wire logic match_capture_pin_a_in,
    output logic match_capture_pin_a_out,
    output logic match_capture_pin_a_oe,
    input wire logic match_capture_pin_b_in,
    output logic match_capture_pin_b_out,
    output logic match_capture_pin_b_oe,
    input wire logic sync_clear_in,
    output logic clear_event_out,
    output logic match_flag_a,
    output logic match_flag_b,
    output logic [CNT_W-1:0] timer_count
);
    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic init;
    logic setup;
    logic wr;
    logic mapped;
    assign init = srst | standby; // standby restarts like reset
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    always_comb begin
        case (paddr)
            tcio_pkg::OFF_TIMER_CONTROL, tcio_pkg::OFF_IO_CONTROL,
            tcio_pkg::OFF_TIMER_COUNT, tcio_pkg::OFF_GENERAL_REG_A,
            tcio_pkg::OFF_GENERAL_REG_B, tcio_pkg::OFF_STATUS,
            tcio_pkg::OFF_MODE, tcio_pkg::OFF_SYNC_SELECT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    // zero wait states keeps the master simple
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    logic [7:0] timer_control_ff;
    logic [7:0] io_control_ff;
    logic [1:0] mode_ff;
    logic sync_select_ff;
    always_ff @(posedge core_clk) begin
        if (init) begin
            timer_control_ff <= tcio_pkg::RST_TIMER_CONTROL;
            io_control_ff <= tcio_pkg::RST_IO_CONTROL;
            mode_ff <= 2'h0;
            sync_select_ff <= 1'b0;
        end else if (wr) begin
            if (paddr == tcio_pkg::OFF_TIMER_CONTROL) begin
                timer_control_ff <= {1'b0, pwdata[6:0]};
            end
            if (paddr == tcio_pkg::OFF_IO_CONTROL) begin
                // bit 7 is not kept, bit 3 held at one
                io_control_ff <= {1'b0, pwdata[6:4], 1'b1, pwdata[2:0]};
            end
            if (paddr == tcio_pkg::OFF_MODE) begin
                mode_ff <= pwdata[1:0];
            end
            if (paddr == tcio_pkg::OFF_SYNC_SELECT) begin
                sync_select_ff <= pwdata[tcio_pkg::SYNC_EN_BIT];
            end
        end
    end

    logic [1:0] clr_sel;
    logic [1:0] edge_sel;
    logic [2:0] src_sel;
    logic [2:0] fn_a;
    logic [2:0] fn_b;
    logic phase_on;
    logic pwm_off;
    assign clr_sel = timer_control_ff[tcio_pkg::CLR_SEL_LSB +: 2];
    assign edge_sel = timer_control_ff[tcio_pkg::EDGE_SEL_LSB +: 2];
    assign src_sel = timer_control_ff[tcio_pkg::SRC_SEL_LSB +: 3];
    assign phase_on = (CHANNEL == tcio_pkg::PHASE_CHANNEL) && mode_ff[tcio_pkg::MODE_PHASE_BIT];
    // pwm modes of the upper pair take the pins away from io control
    assign pwm_off = (CHANNEL >= tcio_pkg::PWM_FIRST_CHANNEL) && mode_ff[tcio_pkg::MODE_PWM_BIT];
    assign fn_a = pwm_off ? tcio_pkg::FN_NO_PIN : io_control_ff[tcio_pkg::REG_A_FN_LSB +: 3];
    assign fn_b = pwm_off ? tcio_pkg::FN_NO_PIN : io_control_ff[tcio_pkg::REG_B_FN_LSB +: 3];

    // ------------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------------
    logic [tcio_pkg::NUM_PIN_IN-1:0] raw_in;
    logic [tcio_pkg::NUM_PIN_IN-1:0] rise;
    logic [tcio_pkg::NUM_PIN_IN-1:0] fall;
    logic [tcio_pkg::NUM_PIN_IN-1:0] lvl;
    assign raw_in = {match_capture_pin_b_in, match_capture_pin_a_in, ext_clock_in_d,
                     ext_clock_in_c, ext_clock_in_b, ext_clock_in_a};
    genvar gi;
    generate
        for (gi = 0; gi < tcio_pkg::NUM_PIN_IN; gi++) begin : g_sync
            logic meta_ff;
            logic stable_ff;
            logic prev_ff;
            // first stage feeds only the second
            always_ff @(posedge core_clk) begin
                if (init) begin
                    meta_ff <= 1'b0;
                    stable_ff <= 1'b0;
                    prev_ff <= 1'b0;
                end else begin
                    meta_ff <= raw_in[gi];
                    stable_ff <= meta_ff;
                    prev_ff <= stable_ff;
                end
            end
            assign lvl[gi] = stable_ff;
            assign rise[gi] = stable_ff & ~prev_ff;
            assign fall[gi] = ~stable_ff & prev_ff;
        end
    endgenerate

    // ------------------------------------------------------------------
    // count clock selection
    // ------------------------------------------------------------------
    logic [2:0] div_ff;
    logic [2:0] div_prev_ff;
    always_ff @(posedge core_clk) begin
        if (init) begin
            div_ff <= 3'h0;
            div_prev_ff <= 3'h0;
        end else begin
            div_ff <= div_ff + 3'h1;
            div_prev_ff <= div_ff;
        end
    end

    logic tick;
    logic [1:0] ext_idx;
    logic [2:0] div_fall;
    assign ext_idx = src_sel[1:0];
    assign div_fall = div_prev_ff & ~div_ff;
    always_comb begin
        tick = 1'b0;
        if (!src_sel[2]) begin
            // divided internal sources count on the falling phase only; phi counts every cycle
            case (src_sel[1:0])
                2'h0: tick = 1'b1;
                2'h1: tick = div_fall[0];
                2'h2: tick = div_fall[1];
                default: tick = div_fall[2];
            endcase
        end else begin
            // external edge follows the edge field
            if (edge_sel[1]) begin
                tick = rise[ext_idx] | fall[ext_idx];
            end else if (edge_sel == tcio_pkg::EDGE_FALL) begin
                tick = fall[ext_idx];
            end else begin
                tick = rise[ext_idx];
            end
        end
    end

    // quadrature from clocks a and b; overrides both fields
    logic ph_up;
    logic ph_dn;
    assign ph_up = ((rise[0] | fall[0]) & (lvl[0] ^ lvl[1])) |
                   ((rise[1] | fall[1]) & ~(lvl[0] ^ lvl[1]));
    assign ph_dn = ((rise[0] | fall[0]) & ~(lvl[0] ^ lvl[1])) |
                   ((rise[1] | fall[1]) & (lvl[0] ^ lvl[1]));

    // ------------------------------------------------------------------
    // compare and capture events
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] gra_ff;
    logic [CNT_W-1:0] grb_ff;
    logic moved_ff;
    logic cmp_a_ev;
    logic cmp_b_ev;
    logic cap_a_ev;
    logic cap_b_ev;
    logic clr_now;

    // match only once per count value, checked after the counter moved
    assign cmp_a_ev = ~fn_a[2] & moved_ff & (count_ff == gra_ff);
    assign cmp_b_ev = ~fn_b[2] & moved_ff & (count_ff == grb_ff);
    always_comb begin
        case (fn_a)
            tcio_pkg::FN_CAP_RISE: cap_a_ev = rise[tcio_pkg::IN_PIN_A];
            tcio_pkg::FN_CAP_FALL: cap_a_ev = fall[tcio_pkg::IN_PIN_A];
            tcio_pkg::FN_CAP_BOTH: cap_a_ev = rise[tcio_pkg::IN_PIN_A] | fall[tcio_pkg::IN_PIN_A];
            default: cap_a_ev = 1'b0;
        endcase
        case (fn_b)
            tcio_pkg::FN_CAP_RISE: cap_b_ev = rise[tcio_pkg::IN_PIN_B];
            tcio_pkg::FN_CAP_FALL: cap_b_ev = fall[tcio_pkg::IN_PIN_B];
            tcio_pkg::FN_CAP_BOTH: cap_b_ev = rise[tcio_pkg::IN_PIN_B] | fall[tcio_pkg::IN_PIN_B];
            default: cap_b_ev = 1'b0;
        endcase
    end

    // clear source: match or capture of the chosen register, or the group's synchronised clear
    always_comb begin
        case (clr_sel)
            tcio_pkg::CLR_REG_A: clr_now = cmp_a_ev | cap_a_ev;
            tcio_pkg::CLR_REG_B: clr_now = cmp_b_ev | cap_b_ev;
            // joins others only when the sync select says so
            tcio_pkg::CLR_SYNC: clr_now = sync_select_ff & sync_clear_in;
            default: clr_now = 1'b0;
        endcase
    end
    // own clears are offered to the synchronised group
    assign clear_event_out = sync_select_ff & (clr_sel == tcio_pkg::CLR_REG_A ||
                             clr_sel == tcio_pkg::CLR_REG_B) & clr_now;

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    logic wr_cnt;
    assign wr_cnt = wr && paddr == tcio_pkg::OFF_TIMER_COUNT;
    always_ff @(posedge core_clk) begin
        if (init) begin
            count_ff <= '0;
            moved_ff <= 1'b0;
        end else begin
            moved_ff <= 1'b0;
            if (wr_cnt) begin
                count_ff <= pwdata[CNT_W-1:0];
            end else if (clr_now) begin
                count_ff <= '0;
            end else if (phase_on) begin
                if (ph_up) begin
                    count_ff <= count_ff + 1'b1;
                    moved_ff <= 1'b1;
                end else if (ph_dn) begin
                    count_ff <= count_ff - 1'b1;
                    moved_ff <= 1'b1;
                end
            end else if (tick) begin
                count_ff <= count_ff + 1'b1;
                moved_ff <= 1'b1;
            end
        end
    end
    assign timer_count = count_ff;

    // ------------------------------------------------------------------
    // general registers; capture beats a software write
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (init) begin
            gra_ff <= '1;
            grb_ff <= '1;
        end else begin
            if (cap_a_ev) begin
                gra_ff <= count_ff;
            end else if (wr && paddr == tcio_pkg::OFF_GENERAL_REG_A) begin
                gra_ff <= pwdata[CNT_W-1:0];
            end
            if (cap_b_ev) begin
                grb_ff <= count_ff;
            end else if (wr && paddr == tcio_pkg::OFF_GENERAL_REG_B) begin
                grb_ff <= pwdata[CNT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // match flags: write 0 clears, a new event in that cycle wins
    // ------------------------------------------------------------------
    logic wr_stat;
    assign wr_stat = wr && paddr == tcio_pkg::OFF_STATUS;
    always_ff @(posedge core_clk) begin
        if (init) begin
            match_flag_a <= 1'b0;
            match_flag_b <= 1'b0;
        end else begin
            match_flag_a <= (cmp_a_ev | cap_a_ev) |
                (match_flag_a & ~(wr_stat & ~pwdata[tcio_pkg::FLAG_A_BIT]));
            match_flag_b <= (cmp_b_ev | cap_b_ev) |
                (match_flag_b & ~(wr_stat & ~pwdata[tcio_pkg::FLAG_B_BIT]));
        end
    end

    // ------------------------------------------------------------------
    // compare output pins
    // ------------------------------------------------------------------
    // drive level after a match for one function code
    function automatic logic pin_next(input logic [2:0] fn, input logic cur);
        logic res;
        res = cur;
        case (fn)
            tcio_pkg::FN_DRIVE0: res = 1'b0;
            tcio_pkg::FN_DRIVE1: res = 1'b1;
            // no toggle on the phase channel, it drives one
            tcio_pkg::FN_TOGGLE: res = (CHANNEL == tcio_pkg::PHASE_CHANNEL) ? 1'b1 : ~cur;
            default: res = cur;
        endcase
        return res;
    endfunction

    // pins stay low from reset until the first match
    always_ff @(posedge core_clk) begin
        if (init) begin
            match_capture_pin_a_out <= 1'b0;
            match_capture_pin_b_out <= 1'b0;
        end else begin
            if (cmp_a_ev) begin
                match_capture_pin_a_out <= pin_next(fn_a, match_capture_pin_a_out);
            end
            if (cmp_b_ev) begin
                match_capture_pin_b_out <= pin_next(fn_b, match_capture_pin_b_out);
            end
        end
    end
    // driven only in compare mode with a pin function
    assign match_capture_pin_a_oe = ~fn_a[2] & (fn_a != tcio_pkg::FN_NO_PIN);
    assign match_capture_pin_b_oe = ~fn_b[2] & (fn_b != tcio_pkg::FN_NO_PIN);

    // ------------------------------------------------------------------
    // read data, latched in the setup cycle
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (init) begin
            prdata <= 32'h0;
        end else if (setup) begin
            case (paddr)
                tcio_pkg::OFF_TIMER_CONTROL: prdata <= {24'h0, timer_control_ff};
                tcio_pkg::OFF_IO_CONTROL: prdata <= {24'h0, io_control_ff};
                tcio_pkg::OFF_TIMER_COUNT: prdata <= 32'(count_ff);
                tcio_pkg::OFF_GENERAL_REG_A: prdata <= 32'(gra_ff);
                tcio_pkg::OFF_GENERAL_REG_B: prdata <= 32'(grb_ff);
                tcio_pkg::OFF_STATUS: prdata <= {30'h0, match_flag_b, match_flag_a};
                tcio_pkg::OFF_MODE: prdata <= {30'h0, mode_ff};
                tcio_pkg::OFF_SYNC_SELECT: prdata <= {31'h0, sync_select_ff};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_clr_reg_a;
        @(posedge core_clk) disable iff (init)
        (clr_sel == tcio_pkg::CLR_REG_A && (cmp_a_ev || cap_a_ev) && !wr_cnt) |=> count_ff == '0;
    endproperty
    a_clr_reg_a: assert property (p_clr_reg_a) else $error("reg a event did not clear");

    property p_no_clr;
        @(posedge core_clk) disable iff (init)
        (clr_sel == tcio_pkg::CLR_NONE) |-> !clr_now;
    endproperty
    a_no_clr: assert property (p_no_clr) else $error("clear with clear select 00");

    property p_sync_clr;
        @(posedge core_clk) disable iff (init)
        (clr_sel == tcio_pkg::CLR_SYNC && sync_select_ff && sync_clear_in && !wr_cnt)
        |=> count_ff == '0;
    endproperty
    a_sync_clr: assert property (p_sync_clr) else $error("synchronised clear missed");

    property p_capture;
        @(posedge core_clk) disable iff (init)
        cap_a_ev |=> (gra_ff == $past(count_ff)) && match_flag_a;
    endproperty
    a_capture: assert property (p_capture) else $error("capture did not copy count");

    property p_drive1;
        @(posedge core_clk) disable iff (init)
        (cmp_b_ev && fn_b == tcio_pkg::FN_DRIVE1) |=> match_capture_pin_b_out;
    endproperty
    a_drive1: assert property (p_drive1) else $error("pin b not driven high");

    property p_toggle;
        @(posedge core_clk) disable iff (init)
        (cmp_a_ev && fn_a == tcio_pkg::FN_TOGGLE) |=> match_capture_pin_a_out ==
            ((CHANNEL == tcio_pkg::PHASE_CHANNEL) ? 1'b1 : !$past(match_capture_pin_a_out));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle output wrong");

    property p_io_bit3;
        @(posedge core_clk) disable iff (init)
        (setup && paddr == tcio_pkg::OFF_IO_CONTROL) |=> prdata[3] && !prdata[7];
    endproperty
    a_io_bit3: assert property (p_io_bit3) else $error("io control bit 3 not one");

    property p_phi_count;
        @(posedge core_clk) disable iff (init)
        (src_sel == 3'h0 && !phase_on && !clr_now && !wr_cnt)
        |=> count_ff == $past(count_ff) + 1'b1;
    endproperty
    a_phi_count: assert property (p_phi_count) else $error("phi source did not count");

    property p_half_rate;
        @(posedge core_clk) disable iff (init)
        (src_sel == 3'h1 && tick) ##1 (src_sel == 3'h1) |-> !tick;
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("phi/2 ticked twice in a row");

    property p_pwm_off;
        @(posedge core_clk) disable iff (init)
        pwm_off |-> !match_capture_pin_a_oe && !match_capture_pin_b_oe && !cap_a_ev;
    endproperty
    a_pwm_off: assert property (p_pwm_off) else $error("io control active in pwm");

    property p_reset_pin;
        @(posedge core_clk)
        srst |=> !match_capture_pin_a_out && !match_capture_pin_b_out;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("pin not low after reset");
endmodule

// [rtl/tcio_pkg.sv]
/*
 * constants for one timer channel's clock, clear and pin control.
 * assumes a 32-bit apb register port; every register takes one aligned word.
 */
package tcio_pkg;
    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] OFF_IO_CONTROL = 8'h04;
    localparam logic [7:0] OFF_TIMER_COUNT = 8'h08;
    localparam logic [7:0] OFF_GENERAL_REG_A = 8'h0c;
    localparam logic [7:0] OFF_GENERAL_REG_B = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_MODE = 8'h18;
    localparam logic [7:0] OFF_SYNC_SELECT = 8'h1c;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] RST_IO_CONTROL = 8'h08;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CLR_SEL_LSB = 5;
    localparam int EDGE_SEL_LSB = 3;
    localparam int SRC_SEL_LSB = 0;
    localparam int REG_B_FN_LSB = 4;
    localparam int REG_A_FN_LSB = 0;
    localparam int IO_FIXED_ONE_BIT = 3;
    localparam int MODE_PHASE_BIT = 0;
    localparam int MODE_PWM_BIT = 1;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_B_BIT = 1;
    localparam int SYNC_EN_BIT = 0;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_REG_A = 2'h1;
    localparam logic [1:0] CLR_REG_B = 2'h2;
    localparam logic [1:0] CLR_SYNC = 2'h3;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [2:0] FN_NO_PIN = 3'h0;
    localparam logic [2:0] FN_DRIVE0 = 3'h1;
    localparam logic [2:0] FN_DRIVE1 = 3'h2;
    localparam logic [2:0] FN_TOGGLE = 3'h3;
    localparam logic [2:0] FN_CAP_RISE = 3'h4;
    localparam logic [2:0] FN_CAP_FALL = 3'h5;
    localparam logic [2:0] FN_CAP_BOTH = 3'h6;
    localparam int PHASE_CHANNEL = 2;
    localparam int PWM_FIRST_CHANNEL = 3;

    // pin input order in the synchroniser bank
    localparam int NUM_PIN_IN = 6;
    localparam int IN_PIN_A = 4;
    localparam int IN_PIN_B = 5;
endpackage

// [tb/tcio_pins.sv]
/*
 * far side of one timer channel: the four external clocks and the level on pin a.
 * assumes the bench calls its tasks; each level is held long enough for the synchroniser.
 */
`timescale 1ns/1ps
module tcio_pins (
    input wire logic core_clk,
    output logic [3:0] ext_clk,
    output logic pin_a
);
    // clocks stand still at 0 between bursts, pin a starts low
    initial begin
        ext_clk = 4'h0;
        pin_a = 1'b0;
    end
    // n pulses on one clock line, four cycles per level so no edge is lost
    task automatic pulse(input int line, input int n);
        repeat (n) begin
            @(posedge core_clk);
            ext_clk[line] <= 1'b1;
            repeat (4) @(posedge core_clk);
            ext_clk[line] <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask
    // one rising step on pin a
    task automatic raise_a();
        @(posedge core_clk);
        pin_a <= 1'b1;
    endtask
endmodule

// [tb/testbench.sv]
/*
 * self-checking bench for one timer channel (channel 0).
 * assumes tcio_pins as the far side and an apb master written here.
 */
`timescale 1ns/1ps
module testbench;
    logic core_clk, srst, psel, penable, pwrite, pready, pslverr, out_a, oe_a, flag_a, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, q0;
    logic [3:0] ext_clk;
    logic pin_a;
    logic [15:0] d, cnt;
    logic out_b, oe_b, flag_b, clr_ev, stby = 1'b0, sclr = 1'b0, clr_seen = 1'b0;
    int bad_count = 0;
    int check_count = 0;
    tcio_pins tcio_pins_i (.core_clk(core_clk), .ext_clk(ext_clk), .pin_a(pin_a));
    tcio_channel tcio_channel_i (.core_clk(core_clk), .srst(srst), .standby(stby),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clock_in_a(ext_clk[0]),
        .ext_clock_in_b(ext_clk[1]), .ext_clock_in_c(ext_clk[2]), .ext_clock_in_d(ext_clk[3]),
        .match_capture_pin_a_in(pin_a), .match_capture_pin_a_out(out_a),
        .match_capture_pin_a_oe(oe_a), .match_capture_pin_b_in(1'b0),
        .match_capture_pin_b_out(out_b), .match_capture_pin_b_oe(oe_b), .sync_clear_in(sclr),
        .clear_event_out(clr_ev), .match_flag_a(flag_a), .match_flag_b(flag_b), .timer_count(cnt));
    // sticky note that a clear was offered to the synchronised group
    always @(posedge core_clk) if (clr_ev) clr_seen <= 1'b1;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // count advance over eight cycles, or over three pulses of one clock line
    task automatic rate(input logic [7:0] ctl, input int line);
        apb(1'b1, tcio_pkg::OFF_TIMER_CONTROL, {24'h0, ctl});
        apb(1'b0, tcio_pkg::OFF_TIMER_COUNT, 32'h0);
        q0 = q;
        if (line < 0) repeat (5) @(posedge core_clk);
        else begin
            tcio_pins_i.pulse(line, 3);
            repeat (4) @(posedge core_clk);
        end
        apb(1'b0, tcio_pkg::OFF_TIMER_COUNT, 32'h0);
        d = q[15:0] - q0[15:0];
    endtask
    task automatic t_regs();
        apb(1'b0, tcio_pkg::OFF_IO_CONTROL, 32'h0);
        check("io reset", q, 32'h8);
        check("pin a after reset", {oe_a, out_a}, 2'h0);
        apb(1'b1, tcio_pkg::OFF_IO_CONTROL, 32'hff); // bit 3 written as one
        apb(1'b0, tcio_pkg::OFF_IO_CONTROL, 32'h0);
        check("io fixed bit", q, 32'h7f);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", 32'(err), 32'h1);
        check("unmapped data", q, 32'h0);
        // standby in mid-run restarts the channel like reset
        stby <= 1'b1;
        @(posedge core_clk);
        stby <= 1'b0;
        apb(1'b0, tcio_pkg::OFF_IO_CONTROL, 32'h0);
        check("io after standby", q, 32'h8);
        $display("test regs done");
    endtask
    task automatic t_clock();
        for (int k = 0; k < 4; k++) begin
            rate(8'(k), -1);
            check("internal rate", d, 16'(8 >> k));
            rate(8'(k + 4), k);
            check("ext rising", d, 16'h3);
        end
        rate(8'h0c, 0);
        check("ext falling", d, 16'h3);
        rate(8'h14, 0);
        check("ext both", d, 16'h6);
        $display("test clock done");
    endtask
    task automatic t_match();
        apb(1'b1, tcio_pkg::OFF_IO_CONTROL, 32'h0a);
        apb(1'b1, tcio_pkg::OFF_GENERAL_REG_A, 32'h10);
        apb(1'b1, tcio_pkg::OFF_GENERAL_REG_B, 32'h8);
        apb(1'b1, tcio_pkg::OFF_SYNC_SELECT, 32'h1);
        // count stands still here (idle clock a), so it can start from zero
        apb(1'b1, tcio_pkg::OFF_TIMER_COUNT, 32'h0);
        @(negedge core_clk);
        check("count written", 32'(cnt), 32'h0);
        apb(1'b1, tcio_pkg::OFF_TIMER_CONTROL, 32'h20);
        repeat (40) @(posedge core_clk);
        @(negedge core_clk);
        check("drive 1", {oe_a, out_a, flag_a}, 3'h7);
        check("reg b no pin", {oe_b, out_b, flag_b}, 3'h1);
        check("clear offered", 32'(clr_seen), 32'h1);
        apb(1'b0, tcio_pkg::OFF_TIMER_COUNT, 32'h0);
        check("cleared on a", 32'(q <= 32'h11), 32'h1);
        apb(1'b1, tcio_pkg::OFF_IO_CONTROL, 32'h09);
        repeat (40) @(posedge core_clk);
        @(negedge core_clk);
        check("drive 0", {oe_a, out_a}, 2'h2);
        // one match every 17 cycles, so a 17-cycle window holds exactly one toggle
        apb(1'b1, tcio_pkg::OFF_IO_CONTROL, 32'h0b);
        @(negedge core_clk);
        q0 = 32'(out_a);
        repeat (17) @(posedge core_clk);
        @(negedge core_clk);
        check("toggle", 32'(out_a), ~q0 & 32'h1);
        apb(1'b1, tcio_pkg::OFF_IO_CONTROL, 32'h0c);
        apb(1'b1, tcio_pkg::OFF_STATUS, 32'h0);
        @(negedge core_clk);
        check("flag cleared", flag_a, 1'b0);
        tcio_pins_i.raise_a();
        repeat (8) @(posedge core_clk);
        check("capture rise", {oe_a, flag_a}, 2'h1);
        // synchronised clear: one pulse from the group zeroes the count
        apb(1'b1, tcio_pkg::OFF_TIMER_CONTROL, 32'h60);
        repeat (20) @(posedge core_clk);
        sclr <= 1'b1;
        @(posedge core_clk);
        sclr <= 1'b0;
        @(negedge core_clk);
        check("sync clear", 32'(cnt), 32'h0);
        $display("test match done");
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h0, 32'h0};
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        t_regs();
        t_clock();
        t_match();
        end_of_test();
    end
    // bench run is near 500 cycles; cut a hang well after that
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        end_of_test();
    end
endmodule
